/* rtl/rtcc_pkg.sv */
package rtcc_pkg;

  // --------------------------------------------------------------------------
  // register addresses
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_SUBSECOND_TIME = 8'h00;
  localparam logic [7:0] ADDR_SECONDS_AND_START = 8'h01;
  localparam logic [7:0] ADDR_MINUTES_TIME = 8'h02;
  localparam logic [7:0] ADDR_HOURS_FORMAT_CALSIGN = 8'h03;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int START_BIT_POS = 7;
  localparam int MIN_UNUSED_BIT_POS = 7;
  localparam int CALIB_SIGN_POS = 7;
  localparam int HOUR_FMT_POS = 6;
  localparam int AM_PM_POS = 5;
  localparam int TEN_HOUR_POS = 4;

  // --------------------------------------------------------------------------
  // bcd limits and wrap values
  // --------------------------------------------------------------------------
  localparam logic [7:0] SUBSEC_LAST = 8'h99;
  localparam logic [7:0] SEC_LAST = 8'h59;
  localparam logic [7:0] MIN_LAST = 8'h59;
  localparam logic [5:0] HOUR24_LAST = 6'h23;
  localparam logic [4:0] HOUR12_LAST = 5'h12;
  localparam logic [4:0] HOUR12_ROLL = 5'h11;
  localparam logic [4:0] HOUR12_FIRST = 5'h01;
  localparam logic [3:0] BCD_DIGIT_LAST = 4'h9;

  // --------------------------------------------------------------------------
  // values after reset
  // --------------------------------------------------------------------------
  localparam logic [7:0] SUBSEC_RESET = 8'h00;
  localparam logic [6:0] SEC_RESET = 7'h00;
  localparam logic [6:0] MIN_RESET = 7'h00;
  localparam logic [7:0] HOUR_RESET = 8'h00;

  // --------------------------------------------------------------------------
  // oscillator qualification
  // --------------------------------------------------------------------------
  localparam int OSC_QUAL_CYCLES = 32;
  localparam logic [5:0] OSC_QUAL_COUNT = 6'(OSC_QUAL_CYCLES);

  // --------------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic calib_sign;
    logic fmt_12h;
    logic hi5;
    logic hi4;
    logic [3:0] units;
  } hours_s;

endpackage

/* rtl/osc_run_qualifier.sv */
`timescale 1ns/1ps

module osc_run_qualifier (
  input wire logic i_mclk, // system clock
  input wire logic i_rst_n, // synchronous reset, active low
  input wire logic i_ce, // clock enable
  input wire logic i_osc_enable, // oscillator commanded on
  input wire logic i_osc_tick, // one pulse per oscillator cycle
  output logic o_running // oscillator seen running
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [5:0] count;
    logic running;
  } qual_s;

  qual_s st_r;
  qual_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!i_osc_enable) begin
      // stopping the oscillator drops the flag at once
      st_nxt.count = 6'h00;
      st_nxt.running = 1'b0;
    end else if (i_osc_tick && !st_r.running) begin
      st_nxt.count = st_r.count + 6'h01;
      if (st_r.count + 6'h01 >= rtcc_pkg::OSC_QUAL_COUNT) begin
        st_nxt.running = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_running = st_r.running;

endmodule // osc_run_qualifier

/* rtl/rtcc_time_regs_low.sv */
`timescale 1ns/1ps

module rtcc_time_regs_low (
  input wire logic i_mclk, // system clock, 50 MHz
  input wire logic i_rst_n, // synchronous reset, active low
  input wire logic i_ce, // clock enable, freezes all state when low
  input wire logic i_osc_boot_variant, // high: oscillator runs from power-up
  input wire logic i_osc_tick, // one pulse per oscillator cycle
  input wire logic i_hundredth_tick, // one pulse per 1/100 s from the prescaler
  input wire logic i_wr_en, // register write strobe from serial front end
  input wire logic i_rd_en, // register read strobe from serial front end
  input wire logic [7:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  output logic [7:0] o_rdata, // read data, registered
  output logic o_rd_valid, // read data valid pulse
  output logic o_osc_enable, // oscillator power control
  output logic o_osc_running_flag, // oscillator qualified as running
  output logic o_calib_sign, // calibration sign, 1 = negative
  output logic o_day_carry // one-cycle pulse at midnight rollover
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] subsec;
    logic [6:0] sec;
    logic start_bit;
    logic [6:0] min;
    rtcc_pkg::hours_s hour;
    logic [7:0] rdata;
    logic rd_valid;
    logic day_carry;
    logic osc_en;
  } time_s;

  time_s st_r;
  time_s st_nxt;

  rtcc_pkg::reg_req_s req;
  logic osc_running;
  logic count_en;
  logic step_subsec;
  logic [8:0] subsec_step;
  logic [8:0] sec_step;
  logic [8:0] min_step;
  logic [8:0] hour_step;
  logic wr_subsec;
  logic wr_sec;
  logic wr_min;
  logic wr_hour;

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  // two-digit bcd increment; bit 8 is the carry out at the last value
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last);
    logic [8:0] r;
    r = {1'b0, v};
    if (v == last) begin
      r = 9'h100;
    end else if (v[3:0] >= rtcc_pkg::BCD_DIGIT_LAST) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // hour field increment for either format; bit 8 is the day carry
  function automatic logic [8:0] hour_advance(input rtcc_pkg::hours_s h);
    logic [8:0] r;
    logic [4:0] h12;
    // full width so the 24-hour day carry in bit 8 survives
    logic [8:0] s;
    r = {1'b0, h};
    h12 = {h.hi4, h.units};
    if (h.fmt_12h) begin
      if (h12 == rtcc_pkg::HOUR12_ROLL) begin
        // 11 -> 12 flips am/pm; pm -> am is midnight
        r[3:0] = 4'h2;
        r[rtcc_pkg::TEN_HOUR_POS] = 1'b1;
        r[rtcc_pkg::AM_PM_POS] = ~h.hi5;
        r[8] = h.hi5;
      end else if (h12 >= rtcc_pkg::HOUR12_LAST) begin
        r[rtcc_pkg::TEN_HOUR_POS] = 1'b0;
        r[3:0] = rtcc_pkg::HOUR12_FIRST[3:0];
      end else begin
        s = bcd_step({3'h0, h12}, 8'hff);
        r[rtcc_pkg::TEN_HOUR_POS] = s[4];
        r[3:0] = s[3:0];
      end
    end else begin
      s = bcd_step({2'h0, h.hi5, h.hi4, h.units}, {2'h0, rtcc_pkg::HOUR24_LAST});
      r[rtcc_pkg::AM_PM_POS] = s[5];
      r[rtcc_pkg::TEN_HOUR_POS] = s[4];
      r[3:0] = s[3:0];
      r[8] = s[8];
    end
    return r;
  endfunction

  function automatic logic addr_hit(input rtcc_pkg::reg_req_s q, input logic [7:0] a);
    return q.wr_en && (q.addr == a);
  endfunction

  // --------------------------------------------------------------------------
  // oscillator status
  // --------------------------------------------------------------------------
  osc_run_qualifier u_osc_qual (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_osc_enable(st_r.osc_en),
    .i_osc_tick(i_osc_tick),
    .o_running(osc_running)
  );

  // --------------------------------------------------------------------------
  // counting
  // --------------------------------------------------------------------------
  always_comb begin
    req.wr_en = i_wr_en;
    req.rd_en = i_rd_en;
    req.addr = i_addr;
    req.wdata = i_wdata;
  end

  // the start bit gates counting on both variants; with the oscillator off no
  // prescaler ticks arrive, but gating here keeps a stray tick harmless
  assign count_en = st_r.start_bit && st_r.osc_en;
  assign step_subsec = count_en && i_hundredth_tick;

  always_comb begin
    subsec_step = bcd_step(st_r.subsec, rtcc_pkg::SUBSEC_LAST);
    sec_step = bcd_step({1'b0, st_r.sec}, rtcc_pkg::SEC_LAST);
    min_step = bcd_step({1'b0, st_r.min}, rtcc_pkg::MIN_LAST);
    hour_step = hour_advance(st_r.hour);
  end

  always_comb begin
    wr_subsec = addr_hit(req, rtcc_pkg::ADDR_SUBSECOND_TIME);
    wr_sec = addr_hit(req, rtcc_pkg::ADDR_SECONDS_AND_START);
    wr_min = addr_hit(req, rtcc_pkg::ADDR_MINUTES_TIME);
    wr_hour = addr_hit(req, rtcc_pkg::ADDR_HOURS_FORMAT_CALSIGN);
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.day_carry = 1'b0;

    // ripple carries; a write to a field overrides its count in the same cycle
    if (step_subsec) begin
      st_nxt.subsec = subsec_step[7:0];
      if (subsec_step[8]) begin
        st_nxt.sec = sec_step[6:0];
        if (sec_step[8]) begin
          st_nxt.min = min_step[6:0];
          if (min_step[8]) begin
            st_nxt.hour = rtcc_pkg::hours_s'(hour_step[7:0]);
            st_nxt.day_carry = hour_step[8];
          end
        end
      end
    end

    if (wr_subsec) begin
      st_nxt.subsec = req.wdata;
    end
    if (wr_sec) begin
      st_nxt.start_bit = req.wdata[rtcc_pkg::START_BIT_POS];
      st_nxt.sec = req.wdata[6:0];
    end
    if (wr_min) begin
      st_nxt.min = req.wdata[6:0];
    end
    if (wr_hour) begin
      st_nxt.hour.calib_sign = req.wdata[rtcc_pkg::CALIB_SIGN_POS];
      st_nxt.hour.fmt_12h = req.wdata[rtcc_pkg::HOUR_FMT_POS];
      st_nxt.hour.hi5 = req.wdata[rtcc_pkg::AM_PM_POS];
      st_nxt.hour.hi4 = req.wdata[rtcc_pkg::TEN_HOUR_POS];
      st_nxt.hour.units = req.wdata[3:0];
    end

    // oscillator-start variant follows the start bit; the other always runs
    if (i_osc_boot_variant) begin
      st_nxt.osc_en = 1'b1;
    end else begin
      st_nxt.osc_en = st_nxt.start_bit;
    end

    // read path
    if (req.rd_en) begin
      st_nxt.rd_valid = 1'b1;
      case (req.addr)
        rtcc_pkg::ADDR_SUBSECOND_TIME: begin
          st_nxt.rdata = st_r.subsec;
        end
        rtcc_pkg::ADDR_SECONDS_AND_START: begin
          st_nxt.rdata = {st_r.start_bit, st_r.sec};
        end
        rtcc_pkg::ADDR_MINUTES_TIME: begin
          st_nxt.rdata = {1'b0, st_r.min};
        end
        rtcc_pkg::ADDR_HOURS_FORMAT_CALSIGN: begin
          st_nxt.rdata = st_r.hour;
        end
        default: begin
          // other addresses belong to neighbouring blocks
          st_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_r.subsec <= rtcc_pkg::SUBSEC_RESET;
      st_r.sec <= rtcc_pkg::SEC_RESET;
      st_r.start_bit <= 1'b0;
      st_r.min <= rtcc_pkg::MIN_RESET;
      st_r.hour <= rtcc_pkg::hours_s'(rtcc_pkg::HOUR_RESET);
      st_r.rdata <= 8'h00;
      st_r.rd_valid <= 1'b0;
      st_r.day_carry <= 1'b0;
      st_r.osc_en <= 1'b0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign o_rdata = st_r.rdata;
  assign o_rd_valid = st_r.rd_valid;
  assign o_osc_enable = st_r.osc_en;
  assign o_osc_running_flag = osc_running;
  assign o_calib_sign = st_r.hour.calib_sign;
  assign o_day_carry = st_r.day_carry;

endmodule // rtcc_time_regs_low

/* sim/rtcc_time_regs_low_properties.sv */
`timescale 1ns/1ps
module rtcc_time_regs_low_properties (
  input wire logic i_mclk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire logic i_ce, // clock enable
  input wire logic i_osc_boot_variant, // variant select
  input wire logic i_osc_tick, // oscillator pulse
  input wire logic i_wr_en, // write strobe
  input wire logic i_rd_en, // read strobe
  input wire logic [7:0] i_addr, // address
  input wire logic [7:0] i_wdata, // write data
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_rd_valid, // read valid
  input wire logic o_osc_enable, // oscillator on
  input wire logic o_osc_running_flag, // qualified
  input wire logic o_calib_sign, // sign
  input wire logic o_day_carry // day pulse
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic [5:0] ticks_r;
  logic [5:0] ticks_nxt;
  // ----------------------------------------
  // ticks taken while enabled, saturating so long runs never wrap
  // ----------------------------------------
  always_comb begin
    ticks_nxt = ticks_r;
    if (!o_osc_enable) ticks_nxt = 6'h00;
    else if (i_osc_tick && ticks_r != 6'h3f) ticks_nxt = ticks_r + 6'h01;
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) ticks_r <= 6'h00;
    else if (i_ce) ticks_r <= ticks_nxt;
  end
  property p_rd_answer;
    i_ce && i_rd_en |=> o_rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_cause;
    o_rd_valid && $past(i_ce) |-> $past(i_rd_en);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read valid without request");
  property p_min_msb;
    o_rd_valid && $past(i_addr) == rtcc_pkg::ADDR_MINUTES_TIME |-> !o_rdata[7];
  endproperty
  a_min_msb: assert property (p_min_msb) else $error("minutes bit 7 read as one");
  property p_osc_start;
    i_ce && !i_osc_boot_variant && i_wr_en && i_addr == rtcc_pkg::ADDR_SECONDS_AND_START && i_wdata[7]
      |=> o_osc_enable;
  endproperty
  a_osc_start: assert property (p_osc_start) else $error("oscillator not started");
  property p_osc_stop;
    i_ce && !i_osc_boot_variant && i_wr_en && i_addr == rtcc_pkg::ADDR_SECONDS_AND_START && !i_wdata[7]
      |=> !o_osc_enable ##1 !o_osc_running_flag;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped");
  property p_boot_on;
    $past(i_rst_n) && i_osc_boot_variant && i_ce |=> o_osc_enable;
  endproperty
  a_boot_on: assert property (p_boot_on) else $error("boot variant oscillator off");
  property p_calib;
    i_ce && i_wr_en && i_addr == rtcc_pkg::ADDR_HOURS_FORMAT_CALSIGN |=> o_calib_sign == $past(i_wdata[7]);
  endproperty
  a_calib: assert property (p_calib) else $error("calibration sign mismatch");
  property p_flag_rise;
    i_ce && o_osc_enable && i_osc_tick && ticks_r == 6'h1f |=> o_osc_running_flag;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("running flag late");
  property p_flag_early;
    o_osc_running_flag |-> ticks_r >= 6'h20 || !o_osc_enable;
  endproperty
  a_flag_early: assert property (p_flag_early) else $error("running flag early");
  property p_day_pulse;
    o_day_carry |=> !o_day_carry;
  endproperty
  a_day_pulse: assert property (p_day_pulse) else $error("day carry too long");
endmodule // rtcc_time_regs_low_properties

bind rtcc_time_regs_low rtcc_time_regs_low_properties i_rtcc_time_regs_low_properties (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_osc_boot_variant(i_osc_boot_variant),
  .i_osc_tick(i_osc_tick), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_osc_enable(o_osc_enable),
  .o_osc_running_flag(o_osc_running_flag), .o_calib_sign(o_calib_sign), .o_day_carry(o_day_carry));

/* sim/reg_host_model.sv */
`timescale 1ns/1ps
module reg_host_model (
  input wire logic i_mclk, // system clock
  output logic o_wr_en, // write strobe
  output logic o_rd_en, // read strobe
  output logic [7:0] o_addr, // address
  output logic [7:0] o_wdata // write data
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // idle bus shows inverted values so stale data never passes for valid
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_wr_en <= wr;
    o_rd_en <= !wr;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_mclk);
    o_wr_en <= 1'b0;
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
endmodule // reg_host_model

/* sim/rtcc_time_regs_low_test.sv */
`timescale 1ns/1ps
module rtcc_time_regs_low_test;
  localparam logic [7:0] A_SUB = rtcc_pkg::ADDR_SUBSECOND_TIME;
  localparam logic [7:0] A_SEC = rtcc_pkg::ADDR_SECONDS_AND_START;
  localparam logic [7:0] A_MIN = rtcc_pkg::ADDR_MINUTES_TIME;
  localparam logic [7:0] A_HR = rtcc_pkg::ADDR_HOURS_FORMAT_CALSIGN;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_osc_boot_variant = 1'b0;
  logic i_osc_tick = 1'b0, i_hundredth_tick = 1'b0, wr_en, rd_en;
  logic [7:0] addr, wdata, o_rdata, r;
  logic o_rd_valid, o_osc_enable, o_osc_running_flag, o_calib_sign, o_day_carry;
  int miscompares = 0;
  int n_tests = 0;
  int dc_cnt = 0;
  logic [7:0] exp_q[$];
  logic [7:0] hr_in[5] = '{8'h23, 8'h09, 8'h71, 8'h51, 8'h52};
  logic [7:0] hr_out[5] = '{8'h00, 8'h10, 8'h52, 8'h72, 8'h41};
  logic [7:0] dc_exp[5] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00};

  rtcc_time_regs_low i_rtcc_time_regs_low (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_osc_boot_variant(i_osc_boot_variant), .i_osc_tick(i_osc_tick), .i_hundredth_tick(i_hundredth_tick),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(o_rdata),
    .o_rd_valid(o_rd_valid), .o_osc_enable(o_osc_enable), .o_osc_running_flag(o_osc_running_flag),
    .o_calib_sign(o_calib_sign), .o_day_carry(o_day_carry));
  reg_host_model i_reg_host_model (.i_mclk(i_mclk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
    .o_wdata(wdata));

  initial begin
    forever #10 i_mclk = ~i_mclk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_host_model.access(1'b1, a, d);
    @(negedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_reg_host_model.access(1'b0, a, 8'h00);
    repeat (2) @(negedge i_mclk);
  endtask
  task automatic pulse(input logic osc, input int n);
    repeat (n) begin
      @(posedge i_mclk);
      if (osc) i_osc_tick <= 1'b1;
      else i_hundredth_tick <= 1'b1;
      @(posedge i_mclk);
      i_osc_tick <= 1'b0;
      i_hundredth_tick <= 1'b0;
    end
    @(negedge i_mclk);
  endtask
  task automatic do_reset(input logic boot);
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    i_osc_boot_variant <= boot;
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (2) @(negedge i_mclk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // result watchers
  // ----------------------------------------
  always @(negedge i_mclk) begin
    if (o_rd_valid === 1'b1) chk(o_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    if (o_day_carry === 1'b1) dc_cnt++;
  end
  initial begin
    repeat (4000) @(posedge i_mclk);
    miscompares++;
    conclude();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    r = 8'($urandom(32'h3459));
    do_reset(1'b0);
    for (int a = 0; a < 5; a++) rd(8'(a), 8'h00);
    r = {4'($urandom % 10), 4'($urandom % 10)};
    wr(A_SUB, r);
    rd(A_SUB, r);
    wr(A_MIN, 8'hff);
    rd(A_MIN, 8'h7f);
    wr(A_HR, 8'hc5);
    rd(A_HR, 8'hc5);
    chk({7'h0, o_calib_sign}, 8'h01);
    wr(A_SEC, 8'h80);
    chk({7'h0, o_osc_enable}, 8'h01);
    pulse(1'b1, 31);
    chk({7'h0, o_osc_running_flag}, 8'h00);
    pulse(1'b1, 1);
    chk({7'h0, o_osc_running_flag}, 8'h01);
    for (int k = 0; k < 5; k++) begin
      wr(A_HR, hr_in[k]);
      wr(A_MIN, 8'h59);
      wr(A_SEC, 8'hd9);
      wr(A_SUB, 8'h99);
      dc_cnt = 0;
      pulse(1'b0, 1);
      repeat (3) @(negedge i_mclk);
      chk(8'(dc_cnt), dc_exp[k]);
      rd(A_HR, hr_out[k]);
      rd(A_MIN, 8'h00);
      rd(A_SEC, 8'h80);
      rd(A_SUB, 8'h00);
    end
    wr(A_SEC, 8'h00);
    pulse(1'b0, 1);
    rd(A_SUB, 8'h00);
    chk({7'h0, o_osc_running_flag}, 8'h00);
    do_reset(1'b1);
    chk({7'h0, o_osc_enable}, 8'h01);
    pulse(1'b0, 1);
    rd(A_SUB, 8'h00);
    wr(A_SEC, 8'h80);
    pulse(1'b0, 1);
    rd(A_SUB, 8'h01);
    // clock enable low must swallow a tick; bus kept idle meanwhile
    @(posedge i_mclk);
    i_ce <= 1'b0;
    pulse(1'b0, 1);
    @(posedge i_mclk);
    i_ce <= 1'b1;
    rd(A_SUB, 8'h01);
    chk(8'(exp_q.size()), 8'h00);
    conclude();
  end
endmodule // rtcc_time_regs_low_test
